// file: design/gp_core_timer_unit.sv
// Notes on behaviour
// RL1 - Mode field: timer, counter, gated low/high, incremental (the incremental code leaves the count idle)
// RL2 - Run bit zero halts timer always
// RL3 - Software direction: bit 0 up, 1 down
// RL4 - External direction pin, inverted by direction bit
// RL5 - Direction may change running or stopped
// RL6 - Toggle latch flips on overflow or underflow
// RL7 - Software may set or clear toggle latch
// RL8 - Toggle latch and wrap events reach auxiliaries
// RL9 - CPU count write beats hardware update
// RL10 - CPU reads and overwrites count anytime
// RL11 - Timer mode prescale eight times power two
// RL12 - Gated mode: prescaled clock, sense from mode bit
// RL13 - Gated counts only when run and gate active
// RL14 - Gate transitions raise no interrupt
// RL15 - Counter mode steps on selected pin edges
// RL16 - Edge codes: none, rise, fall, any
// RL17 - Sixteen-bit wrap both directions
// RL18 - Pins synchronised before any use
module gp_core_timer_unit
#(
   parameter int COUNT_WIDTH = 16
)
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [core_timer_pkg::ADDR_BITS-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [core_timer_pkg::ADDR_BITS-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic gateCountInputPin,
   input wire logic externalDirectionPin,
   output core_timer_pkg::aux_link_t auxLink,
   output logic irq
);
   import core_timer_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   control_t ctrl;
   logic [COUNT_WIDTH-1:0] coreCount;
   logic [1:0] status;
   logic [1:0] mask;
   logic [PRESCALE_BITS-1:0] prescaler;
   logic [2:0] inSync;
   logic [1:0] dirSync;
   logic awHeld;
   logic wHeld;
   logic [ADDR_BITS-1:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   // Input pin gets a third stage so edges compare two settled samples
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         inSync <= 3'h0;
         dirSync <= 2'h0;
      end
      else
      begin
         inSync <= {inSync[1:0], gateCountInputPin}; // RL18
         dirSync <= {dirSync[0], externalDirectionPin}; // RL18
      end
   end

   logic pinLevel, pinRise, pinFall, dirPin;
   assign pinLevel = inSync[1];
   assign pinRise = inSync[1] & ~inSync[2];
   assign pinFall = ~inSync[1] & inSync[2];
   assign dirPin = dirSync[1];

   // ---------------------------------------------------------------
   // Count step decision
   // ---------------------------------------------------------------
   logic countDown, prescaleTick, gateActive, edgeHit, step;

   // Direction is combinational so a change applies at once
   assign countDown = ctrl.externalDirEnable ? (dirPin ^ ctrl.directionBit) // RL4 RL5
                                             : ctrl.directionBit; // RL3

   // Tick when the low 3+sel prescaler bits are all ones
   logic [PRESCALE_BITS-1:0] tickMask;
   assign tickMask = PRESCALE_BITS'((1 << (PRESCALE_BASE_LOG2 + int'(ctrl.inputSelect))) - 1);
   assign prescaleTick = ((prescaler & tickMask) == tickMask); // RL11

   // Gate sense follows the mode's low bit; no interrupt comes from it
   assign gateActive = (pinLevel == ctrl.modeSelect[0]); // RL12 RL14

   always_comb
   begin
      case (ctrl.inputSelect)
         EDGE_RISE: edgeHit = pinRise; // RL16
         EDGE_FALL: edgeHit = pinFall; // RL16
         EDGE_ANY: edgeHit = pinRise | pinFall; // RL16
         default: edgeHit = 1'b0; // RL16
      endcase
   end

   // Reserved and incremental codes leave the count idle
   always_comb
   begin
      case (ctrl.modeSelect)
         MODE_TIMER: step = ctrl.runBit & prescaleTick; // RL1 RL2 RL11
         MODE_COUNTER: step = ctrl.runBit & edgeHit; // RL1 RL15
         MODE_GATED_LOW,
         MODE_GATED_HIGH: step = ctrl.runBit & gateActive & prescaleTick; // RL13
         default: step = 1'b0; // RL1
      endcase
   end

   // Free-running prescaler keeps phase whatever the mode
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         prescaler <= '0;
      end
      else
      begin
         prescaler <= prescaler + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite write path
   // ---------------------------------------------------------------
   logic wrFire;
   assign wrFire = awHeld & wHeld & ~s_axi_bvalid;

   // Address and data may arrive in either order; each is held once
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= '0;
         wData <= '0;
         wStrb <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else
      begin
         s_axi_awready <= ~awHeld & ~(s_axi_awvalid & s_axi_awready);
         s_axi_wready <= ~wHeld & ~(s_axi_wvalid & s_axi_wready);
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (wrFire)
         begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr == CONTROL_OFFSET || awAddr == COUNT_OFFSET ||
                            awAddr == STATUS_OFFSET || awAddr == MASK_OFFSET)
                           ? 2'h0 : 2'h2;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   logic ctrlWr, countWr, maskWr;
   assign ctrlWr = wrFire & (awAddr == CONTROL_OFFSET) & wStrb[0];
   assign countWr = wrFire & (awAddr == COUNT_OFFSET);
   assign maskWr = wrFire & (awAddr == MASK_OFFSET) & wStrb[0];

   // ---------------------------------------------------------------
   // Count and toggle latch
   // ---------------------------------------------------------------
   logic wrapUp;
   logic wrapDown;
   // A step lost to a CPU count write is no wrap, so the latch holds too
   assign wrapUp = step & ~countWr & ~countDown & (&coreCount); // RL17
   assign wrapDown = step & ~countWr & countDown & (coreCount == '0); // RL17

   // A CPU write wins over a same-cycle hardware step
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         coreCount <= COUNT_RESET[COUNT_WIDTH-1:0];
      end
      else if (countWr)
      begin
         coreCount <= wData[COUNT_WIDTH-1:0]; // RL9 RL10
      end
      else if (step)
      begin
         coreCount <= countDown ? coreCount - 1'b1 : coreCount + 1'b1; // RL17
      end
   end

   // Byte lanes: low byte holds mode fields, high byte the external direction enable and the latch
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl <= control_t'(CONTROL_RESET[10:0] & 11'h5ff);
      end
      else
      begin
         if (ctrlWr)
         begin
            ctrl.inputSelect <= wData[INPUT_SEL_LSB +: 3];
            ctrl.modeSelect <= wData[MODE_SEL_LSB +: 3];
            ctrl.runBit <= wData[RUN_BIT_POS]; // RL2
            ctrl.directionBit <= wData[DIR_BIT_POS]; // RL5
         end
         if (wrFire && awAddr == CONTROL_OFFSET && wStrb[1])
         begin
            ctrl.externalDirEnable <= wData[EXT_DIR_POS];
            ctrl.toggleLatch <= wData[TOGGLE_POS]; // RL7
         end
         else if (wrapUp || wrapDown)
         begin
            ctrl.toggleLatch <= ~ctrl.toggleLatch; // RL6
         end
      end
   end

   // Events registered toward the auxiliary timers
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         auxLink <= '0;
      end
      else
      begin
         auxLink.overflow <= wrapUp & ~countWr; // RL8
         auxLink.underflow <= wrapDown & ~countWr; // RL8
         auxLink.toggleLatch <= ctrl.toggleLatch; // RL8
      end
   end

   // ---------------------------------------------------------------
   // Interrupt status, mask and read path
   // ---------------------------------------------------------------
   logic rdFire;
   logic statusRead;
   assign rdFire = s_axi_arvalid & s_axi_arready;
   assign statusRead = rdFire & (s_axi_araddr == STATUS_OFFSET);

   // Set beats read-clear so a wrap in the read cycle survives
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         status <= STATUS_RESET;
         mask <= MASK_RESET;
         irq <= 1'b0;
      end
      else
      begin
         status[STATUS_OVF_POS] <= (wrapUp & ~countWr) |
                                   (status[STATUS_OVF_POS] & ~statusRead);
         status[STATUS_UNF_POS] <= (wrapDown & ~countWr) |
                                   (status[STATUS_UNF_POS] & ~statusRead);
         if (maskWr)
         begin
            mask <= wData[1:0];
         end
         irq <= |(status & mask);
      end
   end

   logic [31:0] rdValue;
   always_comb
   begin
      rdValue = 32'h0000_0000;
      if (s_axi_araddr == CONTROL_OFFSET)
      begin
         rdValue[10:0] = ctrl & 11'h5ff;
      end
      else if (s_axi_araddr == COUNT_OFFSET)
      begin
         rdValue[COUNT_WIDTH-1:0] = coreCount; // RL10
      end
      else if (s_axi_araddr == STATUS_OFFSET)
      begin
         rdValue[1:0] = status;
      end
      else if (s_axi_araddr == MASK_OFFSET)
      begin
         rdValue[1:0] = mask;
      end
   end

   // One read outstanding; arready drops while the answer stands
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= 2'h0;
      end
      else
      begin
         s_axi_arready <= ~s_axi_rvalid & ~rdFire;
         if (rdFire)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdValue;
            s_axi_rresp <= (s_axi_araddr == CONTROL_OFFSET || s_axi_araddr == COUNT_OFFSET ||
                            s_axi_araddr == STATUS_OFFSET || s_axi_araddr == MASK_OFFSET)
                           ? 2'h0 : 2'h2;
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   halt_when_stopped_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RL2
      !ctrl.runBit && !countWr |=> coreCount == $past(coreCount))
      else $error("count moved while run bit clear");
   cpu_write_wins_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RL9
      countWr |=> coreCount == $past(wData[COUNT_WIDTH-1:0]))
      else $error("cpu write lost to hardware step");
   toggle_on_wrap_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RL6
      (wrapUp || wrapDown) && !(wrFire && awAddr == CONTROL_OFFSET && wStrb[1])
      |=> ctrl.toggleLatch != $past(ctrl.toggleLatch))
      else $error("toggle latch did not flip on wrap");
   up_step_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RL3
      step && !countWr && !ctrl.externalDirEnable && !ctrl.directionBit
      |=> coreCount == $past(coreCount) + 1'b1)
      else $error("software up count wrong");
   ext_dir_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RL4
      step && !countWr && ctrl.externalDirEnable && (dirPin == ctrl.directionBit)
      |=> coreCount == $past(coreCount) + 1'b1)
      else $error("external direction sense wrong");
   gate_closed_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RL13
      ctrl.modeSelect[2:1] == 2'b01 && !gateActive |-> !step)
      else $error("gated timer ran with gate closed");
   reserved_idle_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RL1
      ctrl.modeSelect[2] |-> !step)
      else $error("reserved mode stepped");
   edge_none_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RL16
      ctrl.modeSelect == MODE_COUNTER && (ctrl.inputSelect == EDGE_NONE ||
      ctrl.inputSelect[2]) |-> !step)
      else $error("disabled edge code counted");
   // Every prescale code ticks on low bits all ones, so steps are 8 apart at least
   timer_spacing_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RL11
      step && ctrl.modeSelect == MODE_TIMER
      |=> (!(step && ctrl.modeSelect == MODE_TIMER))[*7])
      else $error("prescaled step too soon");
   wrap_event_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RL8
      wrapUp |=> auxLink.overflow && !auxLink.underflow)
      else $error("overflow not routed");
   irq_level_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      |(status & mask) |=> irq)
      else $error("interrupt not raised");

   cover_overflow_c: cover property (@(posedge core_clk) disable iff (!reset_n) wrapUp);
   cover_underflow_c: cover property (@(posedge core_clk) disable iff (!reset_n) wrapDown);
   cover_edge_c: cover property (@(posedge core_clk) disable iff (!reset_n)
      step && ctrl.modeSelect == MODE_COUNTER);
   cover_conflict_c: cover property (@(posedge core_clk) disable iff (!reset_n)
      countWr && step);

endmodule

// file: design/core_timer_pkg.sv
package core_timer_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses on the AXI4-Lite slave)
   // ---------------------------------------------------------------
   localparam logic [15:0] CONTROL_OFFSET = 16'hff42;
   localparam logic [15:0] COUNT_OFFSET = 16'hff46;
   localparam logic [15:0] STATUS_OFFSET = 16'hff48;
   localparam logic [15:0] MASK_OFFSET = 16'hff4c;
   localparam int ADDR_BITS = 16;

   // ---------------------------------------------------------------
   // Control field positions and reset values
   // ---------------------------------------------------------------
   localparam int INPUT_SEL_LSB = 0;
   localparam int MODE_SEL_LSB = 3;
   localparam int RUN_BIT_POS = 6;
   localparam int DIR_BIT_POS = 7;
   localparam int EXT_DIR_POS = 8;
   localparam int TOGGLE_POS = 10;
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [1:0] STATUS_RESET = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam int STATUS_OVF_POS = 0;
   localparam int STATUS_UNF_POS = 1;

   // Prescaler: base factor 8, doubled per input-select step
   localparam int PRESCALE_BASE_LOG2 = 3;
   localparam int PRESCALE_BITS = 10;

   // ---------------------------------------------------------------
   // Modes and edge selections
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_TIMER = 3'h0,
      MODE_COUNTER = 3'h1,
      MODE_GATED_LOW = 3'h2,
      MODE_GATED_HIGH = 3'h3,
      MODE_INCREMENTAL = 3'h6
   } timer_mode_t;

   localparam logic [2:0] EDGE_NONE = 3'h0;
   localparam logic [2:0] EDGE_RISE = 3'h1;
   localparam logic [2:0] EDGE_FALL = 3'h2;
   localparam logic [2:0] EDGE_ANY = 3'h3;

   typedef struct packed {
      logic toggleLatch;
      logic reservedGap; // Bit 9 stays unused so the latch lands on bit 10
      logic externalDirEnable;
      logic directionBit;
      logic runBit;
      logic [2:0] modeSelect;
      logic [2:0] inputSelect;
   } control_t;

   // Events routed to the auxiliary timers
   typedef struct packed {
      logic toggleLatch;
      logic overflow;
      logic underflow;
   } aux_link_t;

endpackage

// file: tb/ext_pins_model.sv
// ------------------------------------------------------------
// Far side: gate / count pin and direction pin
// ------------------------------------------------------------
module ext_pins_model
(
   input wire logic core_clk,
   input wire logic wantGate,
   input wire logic wantDir,
   output logic gateCountInputPin,
   output logic externalDirectionPin
);
   timeunit 1ns;
   timeprecision 1ps;
   int held = 0;

   initial
   begin
      gateCountInputPin = 1'b0;
      externalDirectionPin = 1'b0;
   end

   // A level is held 9 cycles before it may change, so no edge is lost
   always @(posedge core_clk)
   begin
      held <= held + 1;
      if (held >= 8 && {wantGate, wantDir} !== {gateCountInputPin, externalDirectionPin})
      begin
         gateCountInputPin <= wantGate;
         externalDirectionPin <= wantDir;
         held <= 0;
      end
   end
endmodule

// file: tb/tb_gp_core_timer_unit.sv
module tb_gp_core_timer_unit;
   timeunit 1ns;
   timeprecision 1ps;
   import core_timer_pkg::*;

   // ------------------------------------------------------------
   // Signals, clock, design and far side
   // ------------------------------------------------------------
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [15:0] s_axi_awaddr = '0;
   logic [15:0] s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   aux_link_t auxLink;
   logic irq, gateCountInputPin, externalDirectionPin;
   logic wantGate = 1'b0;
   logic wantDir = 1'b0;
   int errCount = 0;
   int checked = 0;
   int seed = 62593;
   int unfSeen = 0;
   int ovfSeen = 0;

   always #25 core_clk = ~core_clk;

   gp_core_timer_unit DUT (.core_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .gateCountInputPin, .externalDirectionPin, .auxLink, .irq);

   ext_pins_model farSide (.core_clk, .wantGate, .wantDir, .gateCountInputPin,
      .externalDirectionPin);

   // Wrap pulses counted as they pass, they stand one cycle only
   always @(posedge core_clk)
   begin
      if (auxLink.underflow === 1'b1)
         unfSeen++;
      if (auxLink.overflow === 1'b1)
         ovfSeen++;
   end

   // ------------------------------------------------------------
   // Bus tasks, comparison and expectations
   // ------------------------------------------------------------
   task automatic give_verdict;
      if (errCount == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] exp, input logic [31:0] act);
      checked++;
      if (act !== exp)
      begin
         errCount++;
         $display("mismatch at %0t: expected %h got %h", $time, exp, act);
      end
   endtask

   task automatic axWrite(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [1:0] r);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge core_clk);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1)
            break;
      end
      s_axi_bready <= 1'b0;
      r = s_axi_bresp;
      // An idle edge keeps a following call from driving bready twice at once
      @(posedge core_clk);
      if (n == 100)
      begin
         errCount++;
         give_verdict();
      end
   endtask

   task automatic axRead(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge core_clk);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1)
            break;
      end
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge core_clk);
      if (n == 100)
      begin
         errCount++;
         give_verdict();
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [1:0] r;
      axWrite(a, d, s, r);
      chk(32'h0000_0000, {30'h0, r});
   endtask

   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      logic [1:0] r;
      axRead(a, d, r);
      chk(32'h0000_0000, {30'h0, r});
   endtask

   function automatic logic [15:0] mk(input int sel, input int mode, input int run,
      input int ud, input int ude);
      return {7'h00, 1'(ude), 1'(ud), 1'(run), 3'(mode), 3'(sel)};
   endfunction

   function automatic bit goesDown(input bit ude, input bit ud, input bit pin);
      return ude ? (pin ^ ud) : ud;
   endfunction

   // Bus latency and prescaler phase blur the window by one step either way
   task automatic runWin(input logic [15:0] ctl, input logic [15:0] start, input int cyc,
      input int steps, input int down);
      logic [31:0] v;
      logic [15:0] e;
      logic [15:0] dd;
      wr(COUNT_OFFSET, {16'h0000, start}, 4'hf);
      wr(CONTROL_OFFSET, {16'h0000, ctl}, 4'hf);
      repeat (cyc) @(posedge core_clk);
      wr(CONTROL_OFFSET, {16'h0000, ctl & 16'hffbf}, 4'h1);
      rd(COUNT_OFFSET, v);
      e = down ? start - 16'(steps) : start + 16'(steps);
      dd = v[15:0] - e;
      if (steps > 0 && (dd == 16'h0001 || dd == 16'hffff))
         e = v[15:0];
      chk({16'h0000, e}, v);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      logic [31:0] v;
      logic [1:0] r;
      int i;
      int f;
      int c;
      bit g;
      repeat (6) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      rd(CONTROL_OFFSET, v);
      chk({16'h0000, CONTROL_RESET}, v);
      rd(COUNT_OFFSET, v);
      chk({16'h0000, COUNT_RESET}, v);
      rd(MASK_OFFSET, v);
      chk({30'h0, MASK_RESET}, v);
      axRead(16'h0010, v, r);
      chk(32'h0000_0002, {30'h0, r});
      chk(32'h0000_0000, v);
      axWrite(16'h0010, 32'h0000_1234, 4'hf, r);
      chk(32'h0000_0002, {30'h0, r});
      // Every prescaler code, random direction and start
      for (i = 0; i < 8; i++)
      begin
         f = 8 << i;
         c = f * 3 + ($random(seed) & 15);
         g = 1'($random(seed));
         runWin(mk(i, MODE_TIMER, 1, g, 0), 16'($random(seed)), c, (c + 4) / f, g);
      end
      // Random starts may have wrapped; clear status before the gate check
      rd(STATUS_OFFSET, v);
      // Direction source and sense, all eight combinations
      for (i = 0; i < 8; i++)
      begin
         wantDir <= i[0];
         repeat (12) @(posedge core_clk);
         runWin(mk(0, MODE_TIMER, 1, i[1], i[2]), 16'h8000, 80, 10,
            goesDown(i[2], i[1], i[0]));
      end
      // Gated modes with each gate level
      for (i = 0; i < 4; i++)
      begin
         wantGate <= i[0];
         repeat (12) @(posedge core_clk);
         runWin(mk(1, 3'(2 + i[1]), 1, 0, 0), 16'h4000, 100, (i[0] == i[1]) ? 6 : 0, 0);
      end
      rd(STATUS_OFFSET, v);
      chk(32'h0000_0000, v);
      runWin(mk(0, MODE_TIMER, 0, 0, 0), 16'h1111, 60, 0, 0);
      for (i = 4; i < 8; i++)
         runWin(mk(0, 3'(i), 1, 0, 0), 16'h2222, 60, 0, 0);
      // Counter mode, three pulses on the input pin per edge code
      for (i = 0; i < 5; i++)
      begin
         wantGate <= 1'b0;
         repeat (12) @(posedge core_clk);
         wr(COUNT_OFFSET, 32'h0000_0100, 4'hf);
         wr(CONTROL_OFFSET, {16'h0000, mk(i, MODE_COUNTER, 1, 0, 0)}, 4'hf);
         repeat (6)
         begin
            wantGate <= ~wantGate;
            repeat (12) @(posedge core_clk);
         end
         repeat (6) @(posedge core_clk);
         rd(COUNT_OFFSET, v);
         chk(32'h0000_0100 + ((i == 3) ? 6 : (i == 0 || i == 4) ? 0 : 3), v);
      end
      // Underflow with its interrupt unmasked
      wr(MASK_OFFSET, 32'h0000_0002, 4'hf);
      rd(STATUS_OFFSET, v);
      unfSeen = 0;
      ovfSeen = 0;
      runWin(mk(0, MODE_TIMER, 1, 1, 0), 16'h0002, 40, 5, 1);
      chk(32'h0000_0001, unfSeen);
      chk(32'h0000_0000, ovfSeen);
      chk(32'h0000_0001, {31'h0, irq});
      rd(CONTROL_OFFSET, v);
      chk(32'h0000_0001, {31'h0, v[TOGGLE_POS]});
      chk(32'h0000_0001, {31'h0, auxLink.toggleLatch});
      rd(STATUS_OFFSET, v);
      chk(32'h0000_0002, v);
      repeat (3) @(posedge core_clk);
      chk(32'h0000_0000, {31'h0, irq});
      // Overflow, masked off
      runWin(mk(0, MODE_TIMER, 1, 0, 0), 16'hfffe, 40, 5, 0);
      chk(32'h0000_0001, ovfSeen);
      chk(32'h0000_0000, {31'h0, irq});
      rd(CONTROL_OFFSET, v);
      chk(32'h0000_0001, {31'h0, v[TOGGLE_POS]});
      rd(STATUS_OFFSET, v);
      chk(32'h0000_0001, v);
      // Software sets and clears the toggle latch
      wr(CONTROL_OFFSET, 32'h0000_0400, 4'hf);
      rd(CONTROL_OFFSET, v);
      chk(32'h0000_0400, v);
      wr(CONTROL_OFFSET, 32'h0000_0000, 4'hf);
      repeat (2) @(posedge core_clk);
      chk(32'h0000_0000, {31'h0, auxLink.toggleLatch});
      give_verdict();
   end
endmodule
